//--- core/alu_pkg.sv
// Constants, opcode enumeration and decode helpers for the accumulator datapath
package alu_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the APB
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_PTR = 8'h08;
	localparam logic [7:0] ADDR_PREFIX = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	//////////////////////////////////////////////////////////////////////////////
	// Flag bit positions and reset values
	localparam int FLAG_C = 0;
	localparam int FLAG_S = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int STATUS_ILLEGAL = 0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [7:0] PREFIX_RESET = 8'h00;
	localparam logic [15:0] INSTR_RESET = 16'h0000;

	//////////////////////////////////////////////////////////////////////////////
	// Instruction encodings
	localparam logic [7:0] GROUP_ACC = 8'h8A;
	localparam logic [7:0] GROUP_BIT_XOR = 8'hBA;
	localparam logic [3:0] LOW_NIBBLE_ACC = 4'hA;
	localparam logic [6:0] GROUP_SUB = 7'h5A;
	localparam logic [6:0] GROUP_MINUS_WITH_BORROW = 7'h7A;
	localparam logic [6:0] GROUP_XOR = 7'h3A;
	localparam logic [3:0] CODE_RL = 4'h4;
	localparam logic [3:0] CODE_RLC = 4'h5;
	localparam logic [3:0] CODE_RR = 4'hC;
	localparam logic [3:0] CODE_RRC = 4'hD;
	localparam logic [3:0] CODE_SLA1 = 4'h2;
	localparam logic [3:0] CODE_ARITH_LEFT_SHIFT_TWO = 4'h3;
	localparam logic [3:0] CODE_ARITH_LEFT_SHIFT_FOUR = 4'h6;
	localparam logic [3:0] CODE_SR = 4'hA;
	localparam logic [3:0] CODE_SRA1 = 4'hF;
	localparam logic [3:0] CODE_ARITH_RIGHT_SHIFT_TWO = 4'hE;
	localparam logic [3:0] CODE_ARITH_RIGHT_SHIFT_FOUR = 4'hB;
	localparam logic [3:0] CODE_BSWAP = 4'h8;
	localparam logic [3:0] CODE_NSWAP = 4'h7;

	typedef enum logic [4:0] {
		op_none, rotate_left, rotate_left_through_carry, rotate_right,
		rotate_right_through_carry, arith_left_shift_one, arith_left_shift_two,
		arith_left_shift_four, logical_right_shift, arith_right_shift_one,
		arith_right_shift_two, arith_right_shift_four, subtract, minus_with_borrow,
		byte_swap, nibble_swap, xor_source, xor_bit
	} alu_op_e;

	//////////////////////////////////////////////////////////////////////////////
	// Decode of an instruction word
	function automatic alu_op_e decode_instr(input logic [15:0] w);
		alu_op_e op;
		op = op_none;
		// Bit form takes the register slot of source xor whose index nibble is 4'hA
		if (w[15:8] == GROUP_BIT_XOR && w[3:0] == LOW_NIBBLE_ACC) begin
			op = xor_bit;
		end else if (w[14:8] == GROUP_SUB) begin
			op = subtract;
		end else if (w[14:8] == GROUP_MINUS_WITH_BORROW) begin
			op = minus_with_borrow;
		end else if (w[14:8] == GROUP_XOR) begin
			op = xor_source;
		end else if (w[15:8] == GROUP_ACC && w[3:0] == LOW_NIBBLE_ACC) begin
			case (w[7:4])
				CODE_RL: op = rotate_left;
				CODE_RLC: op = rotate_left_through_carry;
				CODE_RR: op = rotate_right;
				CODE_RRC: op = rotate_right_through_carry;
				CODE_SLA1: op = arith_left_shift_one;
				CODE_ARITH_LEFT_SHIFT_TWO: op = arith_left_shift_two;
				CODE_ARITH_LEFT_SHIFT_FOUR: op = arith_left_shift_four;
				CODE_SR: op = logical_right_shift;
				CODE_SRA1: op = arith_right_shift_one;
				CODE_ARITH_RIGHT_SHIFT_TWO: op = arith_right_shift_two;
				CODE_ARITH_RIGHT_SHIFT_FOUR: op = arith_right_shift_four;
				CODE_BSWAP: op = byte_swap;
				CODE_NSWAP: op = nibble_swap;
				default: op = op_none;
			endcase
		end
		return op;
	endfunction

	// Operations that read the source operand
	function automatic logic takes_source(input alu_op_e op);
		return (op == subtract) || (op == minus_with_borrow) || (op == xor_source);
	endfunction

endpackage

//--- core/acc_bank.sv
// Accumulator bank with two registered read ports and one write port
`timescale 1ns/1ps
module acc_bank #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output logic [WIDTH-1:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [WIDTH-1:0] rdata_b
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata_a <= mem[raddr_a];
			rdata_b <= mem[raddr_b];
		end
	end
endmodule // acc_bank

//--- core/alu_op_unit.sv
// Combinational shift, rotate, subtract and exclusive-or unit
`timescale 1ns/1ps
module alu_op_unit (
	input alu_pkg::alu_op_e op,
	input wire logic [15:0] acc,
	input wire logic [15:0] src,
	input wire logic carry,
	input wire logic [3:0] bit_idx,
	output logic [15:0] result,
	output logic carry_out,
	output logic sign_out,
	output logic zero_out,
	output logic ov_out,
	output logic wr_acc,
	output logic upd_c,
	output logic upd_s,
	output logic upd_z,
	output logic upd_ov
);
	logic [16:0] diff;

	always_comb begin
		result = acc;
		carry_out = carry;
		ov_out = 1'b0;
		wr_acc = 1'b0;
		upd_c = 1'b0;
		upd_s = 1'b0;
		upd_z = 1'b0;
		upd_ov = 1'b0;
		diff = {1'b0, acc} - {1'b0, src} - {16'h0000, carry & (op == alu_pkg::minus_with_borrow)};
		case (op)
			alu_pkg::rotate_left: begin
				result = {acc[14:0], acc[15]};
				wr_acc = 1'b1;
				upd_s = 1'b1;
			end
			alu_pkg::rotate_left_through_carry: begin
				result = {acc[14:0], carry};
				carry_out = acc[15];
				{wr_acc, upd_c, upd_s, upd_z} = 4'hF;
			end
			alu_pkg::rotate_right: begin
				result = {acc[0], acc[15:1]};
				wr_acc = 1'b1;
				upd_s = 1'b1;
			end
			alu_pkg::rotate_right_through_carry: begin
				result = {carry, acc[15:1]};
				carry_out = acc[0];
				{wr_acc, upd_c, upd_s, upd_z} = 4'hF;
			end
			alu_pkg::arith_left_shift_one: begin
				result = {acc[14:0], 1'b0};
				carry_out = acc[15];
				{wr_acc, upd_c, upd_s, upd_z} = 4'hF;
			end
			alu_pkg::arith_left_shift_two: begin
				result = {acc[13:0], 2'h0};
				carry_out = acc[14];
				{wr_acc, upd_c, upd_s, upd_z} = 4'hF;
			end
			alu_pkg::arith_left_shift_four: begin
				result = {acc[11:0], 4'h0};
				carry_out = acc[12];
				{wr_acc, upd_c, upd_s, upd_z} = 4'hF;
			end
			alu_pkg::logical_right_shift: begin
				result = {1'b0, acc[15:1]};
				carry_out = acc[0];
				{wr_acc, upd_c, upd_s, upd_z} = 4'hF;
			end
			alu_pkg::arith_right_shift_one: begin
				result = {acc[15], acc[15:1]};
				carry_out = acc[0];
				{wr_acc, upd_c, upd_z} = 3'h7;
			end
			alu_pkg::arith_right_shift_two: begin
				result = {{2{acc[15]}}, acc[15:2]};
				carry_out = acc[1];
				{wr_acc, upd_c, upd_z} = 3'h7;
			end
			alu_pkg::arith_right_shift_four: begin
				result = {{4{acc[15]}}, acc[15:4]};
				carry_out = acc[3];
				{wr_acc, upd_c, upd_z} = 3'h7;
			end
			alu_pkg::subtract, alu_pkg::minus_with_borrow: begin
				result = diff[15:0];
				carry_out = diff[16];
				ov_out = (acc[15] != src[15]) && (diff[15] != acc[15]);
				{wr_acc, upd_c, upd_s, upd_z, upd_ov} = 5'h1F;
			end
			alu_pkg::byte_swap: begin
				result = {acc[7:0], acc[15:8]};
				wr_acc = 1'b1;
				upd_s = 1'b1;
			end
			alu_pkg::nibble_swap: begin
				result = {acc[11:8], acc[15:12], acc[3:0], acc[7:4]};
				wr_acc = 1'b1;
				upd_s = 1'b1;
			end
			alu_pkg::xor_source: begin
				result = acc ^ src;
				{wr_acc, upd_s, upd_z} = 3'h7;
			end
			alu_pkg::xor_bit: begin
				carry_out = carry ^ acc[bit_idx];
				upd_c = 1'b1;
			end
			default: begin
			end
		endcase
	end

	assign sign_out = result[15];
	assign zero_out = (result == 16'h0000);
endmodule // alu_op_unit

//--- core/accumulator_datapath.sv
// Accumulator datapath top: APB register slave, sequencer and flag state
// Overview of operation
// - Rotate left through carry: carry into bit 0, old bit 15 to carry; C,S,Z.
// - Rotate right: bits 15..1 move down, old bit 0 to bit 15; sign only.
// - Rotate right through carry: carry into bit 15, old bit 0 to carry; C,S,Z.
// - Left shifts by 1, 2, 4 fill zeros; carry takes last bit out; C,S,Z.
// - Logical right shift inserts zero at bit 15, old bit 0 into carry.
// - Arithmetic right shifts replicate bit 15; last bit shifted out goes to carry.
// - Right shifts update C and Z; only logical shift touches sign.
// - Subtract: accumulator minus source; C,S,Z,OV updated.
// - Subtract with borrow: accumulator minus source minus carry.
// - Source is 16 bits; immediate high byte comes from prefix register.
// - Byte swap exchanges high and low bytes; sign only.
// - Nibble swap exchanges nibbles within each byte; sign only.
// - Source xor replaces accumulator with accumulator xor source; S,Z.
// - Bit xor: carry becomes carry xor selected accumulator bit.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module accumulator_datapath #(
	parameter int ACC_COUNT = 16,
	localparam int AW = $clog2(ACC_COUNT)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [3:0] status_flags,
	output logic [AW-1:0] accumulator_pointer
);

	//////////////////////////////////////////////////////////////////////////////
	// Declarations
	typedef enum logic [1:0] {st_idle, st_fetch, st_exec, st_done} seq_state_e;

	seq_state_e state;
	seq_state_e next_state;
	logic [15:0] instr;
	logic [7:0] prefix_high_byte_reg;
	logic [3:0] flags;
	logic carry_flag;
	logic sign_flag;
	logic zero_flag;
	logic ov_flag;
	logic last_illegal;
	logic err;
	logic access;
	logic wr_req;
	logic rd_req;
	logic hit_instr;
	logic hit_acc;
	logic hit_ptr;
	logic hit_prefix;
	logic hit_flags;
	logic hit_status;
	logic mapped;
	logic instr_start;
	logic acc_write;
	logic acc_read;
	logic exec;
	alu_pkg::alu_op_e op;
	logic src_is_reg;
	logic [AW-1:0] src_index;
	logic [15:0] src_word;
	logic [15:0] acc_word;
	logic [15:0] bank_src;
	logic bank_we;
	logic [15:0] bank_wdata;
	logic [15:0] result;
	logic carry_out;
	logic sign_out;
	logic zero_out;
	logic ov_out;
	logic wr_acc;
	logic upd_c;
	logic upd_s;
	logic upd_z;
	logic upd_ov;

	//////////////////////////////////////////////////////////////////////////////
	// Address decode and request qualification
	assign access = clk_en && psel && penable && (state == st_idle);
	assign wr_req = access && pwrite;
	assign rd_req = access && !pwrite;
	assign hit_instr = (paddr == alu_pkg::ADDR_INSTR);
	assign hit_acc = (paddr == alu_pkg::ADDR_ACC);
	assign hit_ptr = (paddr == alu_pkg::ADDR_PTR);
	assign hit_prefix = (paddr == alu_pkg::ADDR_PREFIX);
	assign hit_flags = (paddr == alu_pkg::ADDR_FLAGS);
	assign hit_status = (paddr == alu_pkg::ADDR_STATUS);
	assign mapped = hit_instr || hit_acc || hit_ptr || hit_prefix || hit_flags || hit_status;
	assign instr_start = wr_req && hit_instr;
	assign acc_write = wr_req && hit_acc;
	assign acc_read = rd_req && hit_acc;
	assign exec = clk_en && (state == st_exec);

	//////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (instr_start || acc_read) begin
					next_state = st_fetch;
				end else if (access) begin
					next_state = st_done;
				end
			end
			st_fetch: begin
				if (pwrite) begin
					next_state = st_exec;
				end else begin
					next_state = st_done;
				end
			end
			st_exec: begin
				next_state = st_done;
			end
			st_done: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// APB answer
	// Gated by the enable so a frozen done state cannot answer twice
	assign pready = (state == st_done) && clk_en;
	assign pslverr = pready && err;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err <= 1'b0;
		end else if (access) begin
			err <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (rd_req) begin
				prdata <= 32'h0000_0000;
				if (hit_instr) begin
					prdata[15:0] <= instr;
				end
				if (hit_ptr) begin
					prdata[AW-1:0] <= accumulator_pointer;
				end
				if (hit_prefix) begin
					prdata[7:0] <= prefix_high_byte_reg;
				end
				if (hit_flags) begin
					prdata[3:0] <= flags;
				end
				if (hit_status) begin
					prdata[alu_pkg::STATUS_ILLEGAL] <= last_illegal;
				end
			end else if (state == st_fetch && !pwrite) begin
				prdata <= {16'h0000, acc_word};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Instruction register and decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= alu_pkg::INSTR_RESET;
		end else if (clk_en && instr_start) begin
			instr <= pwdata[15:0];
		end
	end

	assign op = alu_pkg::decode_instr(instr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_illegal <= 1'b0;
		end else if (exec) begin
			last_illegal <= (op == alu_pkg::op_none);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Active accumulator selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator_pointer <= '0;
		end else if (clk_en && wr_req && hit_ptr) begin
			accumulator_pointer <= pwdata[AW-1:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Source operand path
	assign src_is_reg = instr[15];
	// Register form names an accumulator, which must differ from the active one
	assign src_index = instr[AW-1:0];

	always_comb begin
		if (src_is_reg) begin
			src_word = bank_src;
		end else begin
			src_word = {prefix_high_byte_reg, instr[7:0]};
		end
	end

	// Prefix is consumed by the instruction that takes a source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prefix_high_byte_reg <= alu_pkg::PREFIX_RESET;
		end else if (clk_en) begin
			if (wr_req && hit_prefix) begin
				prefix_high_byte_reg <= pwdata[7:0];
			end else if (exec && alu_pkg::takes_source(op)) begin
				prefix_high_byte_reg <= alu_pkg::PREFIX_RESET;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Accumulator storage
	assign bank_we = acc_write || (exec && wr_acc);
	assign bank_wdata = acc_write ? pwdata[15:0] : result;

	acc_bank #(
		.WIDTH(16),
		.DEPTH(ACC_COUNT)
	) u_bank (
		.clk(pclk),
		.ce(clk_en),
		.we(bank_we),
		.waddr(accumulator_pointer),
		.wdata(bank_wdata),
		.raddr_a(accumulator_pointer),
		.rdata_a(acc_word),
		.raddr_b(src_index),
		.rdata_b(bank_src)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Operation unit
	alu_op_unit u_unit (
		.op(op),
		.acc(acc_word),
		.src(src_word),
		.carry(flags[alu_pkg::FLAG_C]),
		.bit_idx(instr[7:4]),
		.result(result),
		.carry_out(carry_out),
		.sign_out(sign_out),
		.zero_out(zero_out),
		.ov_out(ov_out),
		.wr_acc(wr_acc),
		.upd_c(upd_c),
		.upd_s(upd_s),
		.upd_z(upd_z),
		.upd_ov(upd_ov)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_C];
		end else if (clk_en) begin
			if (wr_req && hit_flags) begin
				carry_flag <= pwdata[alu_pkg::FLAG_C];
			end else if (exec && upd_c) begin
				carry_flag <= carry_out;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sign_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_S];
		end else if (clk_en) begin
			if (wr_req && hit_flags) begin
				sign_flag <= pwdata[alu_pkg::FLAG_S];
			end else if (exec && upd_s) begin
				sign_flag <= sign_out;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_Z];
		end else if (clk_en) begin
			if (wr_req && hit_flags) begin
				zero_flag <= pwdata[alu_pkg::FLAG_Z];
			end else if (exec && upd_z) begin
				zero_flag <= zero_out;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ov_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_OV];
		end else if (clk_en) begin
			if (wr_req && hit_flags) begin
				ov_flag <= pwdata[alu_pkg::FLAG_OV];
			end else if (exec && upd_ov) begin
				ov_flag <= ov_out;
			end
		end
	end

	// Flags as seen on the port and by software
	always_comb begin
		flags = alu_pkg::FLAGS_RESET;
		flags[alu_pkg::FLAG_C] = carry_flag;
		flags[alu_pkg::FLAG_S] = sign_flag;
		flags[alu_pkg::FLAG_Z] = zero_flag;
		flags[alu_pkg::FLAG_OV] = ov_flag;
	end

	assign status_flags = flags;

endmodule // accumulator_datapath

//--- bench/accumulator_datapath_checker_sva.sv
// Concurrent checks on the accumulator datapath ports
`timescale 1ns/1ps
module accumulator_datapath_checker #(
	parameter int ACC_COUNT = 16,
	localparam int AW = $clog2(ACC_COUNT)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] status_flags,
	input wire logic [AW-1:0] accumulator_pointer
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr inside {alu_pkg::ADDR_INSTR, alu_pkg::ADDR_ACC, alu_pkg::ADDR_PTR,
		alu_pkg::ADDR_PREFIX, alu_pkg::ADDR_FLAGS, alu_pkg::ADDR_STATUS};
	sequence s_access_start;
		psel && $rose(penable);
	endsequence
	sequence s_exec_write;
		psel && pwrite && (paddr == alu_pkg::ADDR_INSTR || paddr == alu_pkg::ADDR_FLAGS);
	endsequence
	//////////////////////////////////////////////////////////////////////////////
	chk_answer_bound: assert property (s_access_start |-> ##[0:10] pready)
		else $error("access phase not answered in time");
	chk_ready_inside: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
		else $error("error response does not match address map");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000
		&& (!pslverr || prdata == 32'h0000_0000))
		else $error("read data upper half or error data not zero");
	chk_frozen_idle: assert property (!clk_en |-> !pready)
		else $error("ready while clock enable low");
	chk_flags_cause: assert property (!$stable(status_flags) |-> $past(psel && pwrite
		&& (paddr == alu_pkg::ADDR_INSTR || paddr == alu_pkg::ADDR_FLAGS)))
		else $error("flags changed without a write");
	chk_ptr_cause: assert property (!$stable(accumulator_pointer) |->
		$past(psel && pwrite && paddr == alu_pkg::ADDR_PTR))
		else $error("pointer changed without a pointer write");
	chk_exec_frozen: assert property (s_exec_write ##0 !clk_en |=> $stable(status_flags))
		else $error("flags moved while clock enable low");
endmodule // accumulator_datapath_checker

bind accumulator_datapath accumulator_datapath_checker #(.ACC_COUNT(ACC_COUNT)) u_chk (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .status_flags(status_flags), .accumulator_pointer(accumulator_pointer)
);

//--- bench/apb_host_model.sv
// APB requester standing in for the decoder and operand path
`timescale 1ns/1ps
module apb_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic done,
	output logic [31:0] rdata,
	output logic rerr
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= 1'b0;
			paddr <= 8'h00;
			pwdata <= 32'h0;
			done <= 1'b0;
			rdata <= 32'h0;
			rerr <= 1'b0;
		end else begin
			done <= 1'b0;
			if (psel && penable && pready) begin
				psel <= 1'b0;
				penable <= 1'b0;
				done <= 1'b1;
				rdata <= prdata;
				rerr <= pslverr;
				paddr <= ~paddr;
				pwdata <= ~pwdata;
			end else if (psel) begin
				penable <= 1'b1;
			end else if (req) begin
				psel <= 1'b1;
				pwrite <= req_write;
				paddr <= req_addr;
				pwdata <= req_wdata;
			end
		end
	end
endmodule // apb_host_model

//--- bench/accumulator_datapath_tb.sv
// Self-checking bench for the accumulator datapath
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module accumulator_datapath_tb;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic req, req_write, done, rerr, er;
	logic [7:0] paddr, req_addr;
	logic [31:0] pwdata, prdata, req_wdata, rdata, rd;
	logic [3:0] status_flags, accumulator_pointer;
	int err_count = 0;
	int tests_run = 0;
	accumulator_datapath #(.ACC_COUNT(16)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .status_flags(status_flags),
		.accumulator_pointer(accumulator_pointer));
	apb_host_model host (.pclk(pclk), .presetn(presetn), .req(req), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .done(done), .rdata(rdata), .rerr(rerr));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge pclk);
		req <= 1'b0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 40) err_count++;
		rd = rdata;
		er = rerr;
	endtask
	task automatic run_op(input logic [15:0] a0, input logic [3:0] f0, input logic [7:0] pf,
		input logic [15:0] iw, input logic [15:0] a1, input logic [3:0] f1);
		xfer(1'b1, alu_pkg::ADDR_ACC, {16'h0000, a0});
		xfer(1'b1, alu_pkg::ADDR_FLAGS, {28'h0, f0});
		xfer(1'b1, alu_pkg::ADDR_PREFIX, {24'h0, pf});
		xfer(1'b1, alu_pkg::ADDR_INSTR, {16'h0000, iw});
		xfer(1'b0, alu_pkg::ADDR_ACC, 32'h0);
		`CHK(rd, {16'h0000, a1})
		`CHK(status_flags, f1)
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		req = 1'b0;
		req_write = 1'b0;
		req_addr = 8'h00;
		req_wdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, alu_pkg::ADDR_FLAGS, 32'h0);
		`CHK(rd, 32'h0)
		run_op(16'hA345, 4'hF, 8'h00, 16'h8A4A, 16'h468B, 4'hD);
		run_op(16'hA345, 4'h8, 8'h00, 16'h8A5A, 16'h468A, 4'h9);
		run_op(16'hA345, 4'h5, 8'h00, 16'h8ACA, 16'hD1A2, 4'h7);
		run_op(16'hD1A2, 4'h9, 8'h00, 16'h8ADA, 16'hE8D1, 4'hA);
		run_op(16'h8000, 4'h8, 8'h00, 16'h8A2A, 16'h0000, 4'hD);
		run_op(16'hE345, 4'h0, 8'h00, 16'h8A3A, 16'h8D14, 4'h3);
		run_op(16'hE345, 4'h3, 8'h00, 16'h8A6A, 16'h3450, 4'h0);
		run_op(16'hA345, 4'h3, 8'h00, 16'h8AAA, 16'h51A2, 4'h1);
		run_op(16'h0001, 4'h2, 8'h00, 16'h8AFA, 16'h0000, 4'h7);
		run_op(16'h8003, 4'h0, 8'h00, 16'h8AEA, 16'hE000, 4'h1);
		run_op(16'hF987, 4'h1, 8'h00, 16'h8ABA, 16'hFF98, 4'h0);
		run_op(16'h2345, 4'hF, 8'h12, 16'h5A50, 16'h10F5, 4'h0);
		xfer(1'b0, alu_pkg::ADDR_PREFIX, 32'h0);
		`CHK(rd, 32'h0)
		run_op(16'h10F5, 4'h0, 8'h12, 16'h5A50, 16'hFEA5, 4'h3);
		run_op(16'hFEA5, 4'h0, 8'h7F, 16'h5AFF, 16'h7EA6, 4'h8);
		run_op(16'h2345, 4'h1, 8'h12, 16'h7A50, 16'h10F4, 4'h0);
		run_op(16'h1251, 4'h9, 8'h12, 16'h7A50, 16'h0000, 4'h4);
		run_op(16'h1250, 4'h1, 8'h12, 16'h7A50, 16'hFFFF, 4'h3);
		run_op(16'h2345, 4'hF, 8'h00, 16'h8A8A, 16'h4523, 4'hD);
		run_op(16'h2345, 4'h2, 8'h00, 16'h8A7A, 16'h3254, 4'h0);
		run_op(16'h2345, 4'hF, 8'h0F, 16'h3A0F, 16'h2C4A, 4'h9);
		run_op(16'h8000, 4'hF, 8'h00, 16'hBAFA, 16'h8000, 4'hE);
		run_op(16'h0001, 4'h0, 8'h00, 16'hBA0A, 16'h0001, 4'h1);
		xfer(1'b1, alu_pkg::ADDR_PTR, 32'h1);
		xfer(1'b1, alu_pkg::ADDR_ACC, 32'h1250);
		xfer(1'b1, alu_pkg::ADDR_PTR, 32'h0);
		`CHK(accumulator_pointer, 4'h0)
		run_op(16'h2345, 4'hF, 8'h00, 16'hDA01, 16'h10F5, 4'h0);
		run_op(16'h2345, 4'h5, 8'h00, 16'h8A0A, 16'h2345, 4'h5);
		xfer(1'b1, alu_pkg::ADDR_STATUS, 32'h0);
		xfer(1'b0, alu_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h1)
		xfer(1'b0, 8'h18, 32'h0);
		`CHK({er, rd}, 33'h1_0000_0000)
		fork
			xfer(1'b0, alu_pkg::ADDR_FLAGS, 32'h0);
			begin
				repeat (2) @(posedge pclk);
				clk_en <= 1'b0;
				repeat (3) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		`CHK(rd, 32'h5)
		fork
			xfer(1'b1, alu_pkg::ADDR_FLAGS, 32'hA);
			begin
				repeat (2) @(posedge pclk);
				clk_en <= 1'b0;
				repeat (3) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		xfer(1'b0, alu_pkg::ADDR_FLAGS, 32'h0);
		`CHK(rd, 32'hA)
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		complete_run();
	end
endmodule // accumulator_datapath_tb
